// File: test/fsprg_host_model.sv
/* fsprg_host_model: host side of the three-wire program link.
   Assumes tasks are entered at a falling edge of the 20 MHz clk. */
`timescale 1ns/10ps
module fsprg_host_model (
  input wire logic clk,
  output logic serialClk,
  output logic serialData,
  output logic loadEnable
);
  // ---------------------------------------------------------------
  // frame sender
  // ---------------------------------------------------------------
  // link clock rests low between frames
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadEnable = 1'b0;
  end

  // 400 ns link period, msb first; bits 1:0 pick the register
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      serialData = word[i];
      repeat (4) @(negedge clk);
      serialClk = 1'b1;
      repeat (4) @(negedge clk);
      serialClk = 1'b0;
    end
    serialData = ~word[0]; // released line must not look held
    repeat (4) @(negedge clk);
    loadEnable = 1'b1;
    repeat (4) @(negedge clk);
    loadEnable = 1'b0;
    repeat (8) @(negedge clk);
  endtask : send
endmodule : fsprg_host_model

// File: test/fsprg_regs_sva.sv
/* fsprg_regs_sva: port-level checks of the synthesizer program registers.
   Assumes it is bound onto fsprg_regs and shares its single clock. */
`timescale 1ns/10ps
module fsprg_regs_sva
  import fsprg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chargePumpTristate,
  input wire logic chargePumpLowNoise,
  input wire logic countersReset,
  input wire logic powerDown,
  input wire logic ditherEnable,
  input wire logic comparatorTick,
  input wire logic lockDetect,
  input wire logic muxOutOut,
  input wire logic muxOutOe
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // power-down side effects, lock clear allows for register lag
  a_pd_pump_float: assert property (powerDown |-> chargePumpTristate)
    else $error("pump not floated in power-down");
  a_pd_counter_load: assert property (powerDown |-> countersReset)
    else $error("counters not loaded in power-down");
  a_pd_lock_clear: assert property (powerDown [*3] |-> !lockDetect)
    else $error("lock held in power-down");
  // lock is only ever set by a comparator cycle
  a_lock_on_tick: assert property ($rose(lockDetect) |-> comparatorTick ||
    $past(comparatorTick) || $past(comparatorTick, 2))
    else $error("lock rose without a comparator tick");
  a_tick_one_cycle: assert property (comparatorTick |=> !comparatorTick)
    else $error("comparator tick wider than one cycle");
  a_reset_no_tick: assert property (countersReset [*3] |-> !comparatorTick)
    else $error("tick while counters held");
  // the mux pin is only driven high when it shows lock
  a_mux_high_oe: assert property (muxOutOut |-> muxOutOe)
    else $error("mux pin high while floating");
  a_mux_lock_show: assert property (muxOutOe && muxOutOut |-> lockDetect ||
    $past(lockDetect))
    else $error("mux pin high without lock");
  a_dither_bias_excl: assert property (!(ditherEnable && chargePumpLowNoise))
    else $error("dither and low-noise bias together");
endmodule : fsprg_regs_sva

bind fsprg_regs fsprg_regs_sva chk_u (.clk, .arst_n, .chargePumpTristate, .chargePumpLowNoise,
  .countersReset, .powerDown, .ditherEnable, .comparatorTick, .lockDetect, .muxOutOut,
  .muxOutOe);

// File: test/fsprg_regs_tb.sv
/* fsprg_regs_tb: self-checking bench for the program registers.
   Assumes fsprg_host_model drives the link and the bound checker. */
`timescale 1ns/10ps
module fsprg_regs_tb
  import fsprg_pkg::*;
();
  // ---------------------------------------------------------------
  // signals, clock, instances
  // ---------------------------------------------------------------
  logic clk, arst_n, serialClk, serialData, loadEnable, referenceInput, phaseError;
  logic [INT_W-1:0] wholeDivide;
  logic [FRACTION_NUMERATOR_W-1:0] fractionNumerator;
  logic [MOD_W-1:0] fractionModulus, resyncDelay;
  logic [RCNT_W-1:0] referenceRatio;
  logic [CPCUR_W-1:0] chargePumpCurrent;
  logic [RESYNC_W-1:0] resyncCount;
  logic prescalerHigh, chargePumpTristate, chargePumpLowNoise, phasePolarity;
  logic countersReset, powerDown, ditherEnable, comparatorTick, lockDetect;
  logic muxOutOut, muxOutOe;
  int err_count, compares, tickCount;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  fsprg_host_model host_u (.clk, .serialClk, .serialData, .loadEnable);
  fsprg_regs dut_u (.clk, .arst_n, .serialClk, .serialData, .loadEnable, .referenceInput,
    .phaseError, .wholeDivide, .fractionNumerator, .fractionModulus, .resyncDelay,
    .referenceRatio, .prescalerHigh, .chargePumpCurrent, .chargePumpTristate,
    .chargePumpLowNoise, .phasePolarity, .countersReset, .powerDown, .ditherEnable,
    .resyncCount, .comparatorTick, .lockDetect, .muxOutOut, .muxOutOe);

  // tick tally for rate checks
  always @(posedge clk) begin
    if (comparatorTick === 1'b1) tickCount++;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] expected);
    compares++;
    if (seen !== expected) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask : check

  function automatic logic [23:0] fb(input logic fl, input logic [8:0] iv,
    input logic [11:0] fr);
    return {fl, iv, fr, SEL_FEEDBACK};
  endfunction : fb

  function automatic logic [23:0] rw(input logic lc, input logic [2:0] mx, input logic ps,
    input logic [3:0] rc, input logic [11:0] md);
    return {lc, mx, 1'b0, ps, rc, md, SEL_REFERENCE};
  endfunction : rw

  task automatic noise(input logic [1:0] m, input logic d, input logic l);
    host_u.send({20'h0_0000, m, SEL_NOISE});
    check(ditherEnable, d);
    check(chargePumpLowNoise, l);
  endtask : noise

  task automatic ctl(input logic [15:0] v, input logic rs, input logic tr, input logic pd);
    host_u.send({8'h00, v});
    check(countersReset, rs);
    check(chargePumpTristate, tr);
    check(powerDown, pd);
  endtask : ctl

  // whole reference periods, falling edge last; slow enough for the sync
  task automatic ref_cycles(input int n);
    repeat (n) begin
      referenceInput = 1'b1;
      repeat (10) @(negedge clk);
      referenceInput = 1'b0;
      repeat (10) @(negedge clk);
    end
  endtask : ref_cycles

  task automatic ticks(input int n, input int expected);
    int start;
    start = tickCount;
    ref_cycles(n);
    check(24'(tickCount - start), 24'(expected));
  endtask : ticks

  // one bad comparator cycle, then count good ones up to lock
  task automatic lock_after(input int expected);
    int n;
    n = 0;
    phaseError = 1'b1;
    repeat (3) @(negedge clk);
    phaseError = 1'b0;
    repeat (5) @(negedge clk);
    ref_cycles(1);
    check(lockDetect, 1'b0);
    while (lockDetect !== 1'b1 && n < 60) begin
      ref_cycles(1);
      n++;
    end
    check(24'(n), 24'(expected));
  endtask : lock_after

  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  // hang guard, well past the expected run of about 7000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  // main sequence; host keeps fraction_numerator within modulus and int above minimum
  initial begin
    arst_n = 1'b0;
    referenceInput = 1'b0;
    phaseError = 1'b0;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    check(fractionModulus, MOD_RESET);
    host_u.send({20'h0_0000, 2'h0, SEL_NOISE});
    noise(NS_LOWEST_NOISE, 1'b0, 1'b1);
    noise(NS_LOW_NOISE_SPUR, 1'b0, 1'b0);
    noise(NS_LOW_SPUR, 1'b1, 1'b0);
    ctl(16'hA2C2, 1'b0, 1'b0, 1'b0);
    check(chargePumpCurrent, 4'h5);
    check(phasePolarity, 1'b1);
    check(resyncCount, 4'hA);
    host_u.send(rw(1'b0, MUX_FASTLOCK_SW, 1'b1, 4'h1, 12'h041));
    check(referenceRatio, 4'h1);
    check(prescalerHigh, 1'b1);
    check(fractionModulus, MOD_RESET);
    host_u.send(fb(1'b1, 9'h05B, 12'h01E));
    check(fractionModulus, 12'h041);
    check(wholeDivide, 9'h05B);
    check(fractionNumerator, 12'h01E);
    check(chargePumpCurrent, CPCUR_MAX);
    check({muxOutOe, muxOutOut}, 2'b10);
    host_u.send(fb(1'b0, 9'h1FF, 12'h041));
    check(wholeDivide, 9'h1FF);
    check(chargePumpCurrent, 4'h5);
    check(muxOutOe, 1'b0);
    host_u.send(rw(1'b1, MUX_LOCK_DETECT, 1'b0, 4'h1, 12'h123));
    host_u.send(fb(1'b0, 9'h05B, 12'h000));
    check(resyncDelay, 12'h123);
    check(fractionModulus, 12'h041);
    ctl(16'h0006, 1'b1, 1'b0, 1'b0);
    ticks(2, 0);
    ctl(16'h000A, 1'b0, 1'b1, 1'b0);
    ctl(16'h0012, 1'b1, 1'b1, 1'b1);
    ticks(2, 0);
    check(wholeDivide, 9'h05B);
    ctl(16'h0002, 1'b0, 1'b0, 1'b0);
    ticks(6, 6);
    ctl(16'h0802, 1'b0, 1'b0, 1'b0);
    ticks(6, 12);
    host_u.send(rw(1'b0, MUX_LOCK_DETECT, 1'b0, 4'h3, 12'h041));
    ticks(6, 4);
    host_u.send(rw(1'b0, MUX_LOCK_DETECT, 1'b0, 4'h1, 12'h041));
    ctl(16'h0002, 1'b0, 1'b0, 1'b0);
    lock_after(24);
    check({muxOutOe, muxOutOut}, 2'b11);
    ctl(16'h0022, 1'b0, 1'b0, 1'b0);
    lock_after(40);
    host_u.send(fb(1'b0, 9'h05C, 12'h000));
    check(lockDetect, 1'b0);
    // relock, then power down while locked so the lock clear is seen
    lock_after(40);
    ctl(16'h0032, 1'b1, 1'b1, 1'b1);
    check(lockDetect, 1'b0);
    check({muxOutOe, muxOutOut}, 2'b10);
    check(wholeDivide, 9'h05C);
    tally_and_finish();
  end
endmodule : fsprg_regs_tb

// File: verilog/fsprg_pkg.sv
/*
 * fsprg_pkg: field layout, register selects, mode codes and timing
 * constants of the synthesizer program registers.
 * Assumes a 20 MHz system clock and a 24-bit serial word.
 */
package fsprg_pkg;

  // ---------------------------------------------------------------
  // word and register select
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int CTRL_W = 16;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_FEEDBACK = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_NOISE = 2'h3;

  // ---------------------------------------------------------------
  // feedback divider word fields
  // ---------------------------------------------------------------
  localparam int FRACTION_NUMERATOR_LSB = 2;
  localparam int FRACTION_NUMERATOR_W = 12;
  localparam int INT_LSB = 14;
  localparam int INT_W = 9;
  localparam int FASTLOCK_BIT = 23;

  // ---------------------------------------------------------------
  // reference divider word fields
  // ---------------------------------------------------------------
  localparam int MOD_LSB = 2;
  localparam int MOD_W = 12;
  localparam int RCNT_LSB = 14;
  localparam int RCNT_W = 4;
  localparam int PRESC_BIT = 18;
  localparam int MUXSEL_LSB = 20;
  localparam int MUXSEL_W = 3;
  localparam int LOADCTL_BIT = 23;

  // ---------------------------------------------------------------
  // control word fields
  // ---------------------------------------------------------------
  localparam int CNTRST_BIT = 2;
  localparam int CPTRI_BIT = 3;
  localparam int PWRDN_BIT = 4;
  localparam int LOCKWIN_BIT = 5;
  localparam int POLAR_BIT = 6;
  localparam int CPCUR_LSB = 7;
  localparam int CPCUR_W = 4;
  localparam int DOUBLER_BIT = 11;
  localparam int RESYNC_LSB = 12;
  localparam int RESYNC_W = 4;
  localparam logic [CPCUR_W-1:0] CPCUR_MAX = 4'hF;

  // ---------------------------------------------------------------
  // noise and spur mode field and codes
  // ---------------------------------------------------------------
  localparam int NSMODE_LSB = 2;
  localparam int NSMODE_W = 2;
  localparam logic [1:0] NS_LOWEST_NOISE = 2'h0;
  localparam logic [1:0] NS_LOW_NOISE_SPUR = 2'h1;
  localparam logic [1:0] NS_LOW_SPUR = 2'h3;

  // multiplexed output source codes
  localparam logic [2:0] MUX_LOCK_DETECT = 3'h6;
  localparam logic [2:0] MUX_FASTLOCK_SW = 3'h7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h00_0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [MOD_W-1:0] MOD_RESET = 12'h002;

  // ---------------------------------------------------------------
  // lock detect timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int LOCK_NS = 15;
  localparam int UNLOCK_NS = 30;
  localparam int LOCK_CYC = (LOCK_NS * CLK_MHZ) / 1000 < 1 ? 1 : (LOCK_NS * CLK_MHZ) / 1000;
  localparam int UNLOCK_CYC = (UNLOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] LOCK_COUNT_SHORT = 6'h18;
  localparam logic [CNT_W-1:0] LOCK_COUNT_LONG = 6'h28;
  localparam int ERR_W = 4;

endpackage : fsprg_pkg

// File: verilog/fsprg_regs.sv
/*
 * fsprg_regs: serial program registers, double-buffered modulus and
 * digital lock detect of a fractional-N synthesizer core.
 * Assumes the host drives the three-wire link with slow edges relative
 * to the 20 MHz clock and that phase error pulses arrive as pin levels.
 */
// Overview of operation
// - select 00 feedback word, 01 reference word
// - select 10 control word, 11 noise word
// - nine-bit whole divide value from feedback word
// - fast-lock forces maximum charge pump current
// - fast-lock switch pin: ground or float
// - load-control high stores resync delay instead
// - mux source from reference word bits 22:20
// - lock after 24 good comparator cycles
// - lock holds until new channel, power-down or large error
// - lock-window bit selects 24 or 40 cycles
// - reference counter ratio 1 to 15
// - modulus applied only after feedback word write
// - counter reset bit holds counters reset
// - tri-state bit floats charge pump
// - power-down bit keeps register contents
// - power-down loads counters, floats pump, clears lock
// - charge pump current from control bits 10:7
// - doubler bit chooses one or both edges
// - noise mode steers dither and pump bias
`timescale 1ns/10ps
module fsprg_regs
  import fsprg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadEnable,
  input wire logic referenceInput,
  input wire logic phaseError,
  output logic [INT_W-1:0] wholeDivide,
  output logic [FRACTION_NUMERATOR_W-1:0] fractionNumerator,
  output logic [MOD_W-1:0] fractionModulus,
  output logic [MOD_W-1:0] resyncDelay,
  output logic [RCNT_W-1:0] referenceRatio,
  output logic prescalerHigh,
  output logic [CPCUR_W-1:0] chargePumpCurrent,
  output logic chargePumpTristate,
  output logic chargePumpLowNoise,
  output logic phasePolarity,
  output logic countersReset,
  output logic powerDown,
  output logic ditherEnable,
  output logic [RESYNC_W-1:0] resyncCount,
  output logic comparatorTick,
  output logic lockDetect,
  output logic muxOutOut,
  output logic muxOutOe
);
  logic sClk;
  logic sData;
  logic sLe;
  logic sRef;
  logic sErr;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  fsprg_sync uSyncClk (.clk(clk), .arst_n(arst_n), .pinIn(serialClk), .syncOut(sClk));
  fsprg_sync uSyncDat (.clk(clk), .arst_n(arst_n), .pinIn(serialData), .syncOut(sData));
  fsprg_sync uSyncLe (.clk(clk), .arst_n(arst_n), .pinIn(loadEnable), .syncOut(sLe));
  fsprg_sync uSyncRef (.clk(clk), .arst_n(arst_n), .pinIn(referenceInput), .syncOut(sRef));
  fsprg_sync uSyncErr (.clk(clk), .arst_n(arst_n), .pinIn(phaseError), .syncOut(sErr));

  // ---------------------------------------------------------------
  // serial shift and register file
  // ---------------------------------------------------------------
  logic sClkPrev_q, sClkPrev_d, sLePrev_q, sLePrev_d;
  logic [WORD_W-1:0] shift_q, shift_d;
  logic [WORD_W-1:0] fbWord_q, fbWord_d;
  logic [WORD_W-1:0] refWord_q, refWord_d;
  logic [CTRL_W-1:0] ctrlWord_q, ctrlWord_d;
  logic [WORD_W-1:0] nsWord_q, nsWord_d;
  logic [MOD_W-1:0] modPend_q, modPend_d;
  logic [MOD_W-1:0] modAct_q, modAct_d;
  logic [MOD_W-1:0] resync_q, resync_d;
  logic newChannel;
  logic [1:0] sel;

  assign sel = shift_q[SEL_LSB +: SEL_W];

  // shifting and loading stay live in power-down
  always_comb begin
    sClkPrev_d = sClk;
    sLePrev_d = sLe;
    shift_d = shift_q;
    fbWord_d = fbWord_q;
    refWord_d = refWord_q;
    ctrlWord_d = ctrlWord_q;
    nsWord_d = nsWord_q;
    modPend_d = modPend_q;
    modAct_d = modAct_q;
    resync_d = resync_q;
    newChannel = 1'b0;
    if (sClk && !sClkPrev_q) begin
      shift_d = {shift_q[WORD_W-2:0], sData};
    end
    if (sLe && !sLePrev_q) begin
      unique case (sel)
        SEL_FEEDBACK: begin
          fbWord_d = shift_q;
          modAct_d = modPend_q;
          newChannel = 1'b1;
        end
        SEL_REFERENCE: begin
          refWord_d = shift_q;
          if (shift_q[LOADCTL_BIT]) begin
            resync_d = shift_q[MOD_LSB +: MOD_W];
          end else begin
            modPend_d = shift_q[MOD_LSB +: MOD_W];
          end
        end
        SEL_CONTROL: begin
          ctrlWord_d = shift_q[CTRL_W-1:0];
        end
        SEL_NOISE: begin
          nsWord_d = shift_q;
        end
      endcase
    end
  end

  // power-down does not touch these; contents survive it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sClkPrev_q <= 1'b0;
      sLePrev_q <= 1'b0;
      shift_q <= WORD_RESET;
      fbWord_q <= WORD_RESET;
      refWord_q <= WORD_RESET;
      ctrlWord_q <= CTRL_RESET;
      nsWord_q <= WORD_RESET;
      modPend_q <= MOD_RESET;
      modAct_q <= MOD_RESET;
      resync_q <= 12'h000;
    end else begin
      sClkPrev_q <= sClkPrev_d;
      sLePrev_q <= sLePrev_d;
      shift_q <= shift_d;
      fbWord_q <= fbWord_d;
      refWord_q <= refWord_d;
      ctrlWord_q <= ctrlWord_d;
      nsWord_q <= nsWord_d;
      modPend_q <= modPend_d;
      modAct_q <= modAct_d;
      resync_q <= resync_d;
    end
  end

  logic fastLock, pd, cntRst, lockLong, dblr;
  logic [1:0] nsMode;
  logic [RCNT_W-1:0] rRatio;
  assign fastLock = fbWord_q[FASTLOCK_BIT];
  assign pd = ctrlWord_q[PWRDN_BIT];
  assign cntRst = ctrlWord_q[CNTRST_BIT] | pd;
  assign lockLong = ctrlWord_q[LOCKWIN_BIT];
  assign dblr = ctrlWord_q[DOUBLER_BIT];
  assign nsMode = nsWord_q[NSMODE_LSB +: NSMODE_W];
  assign rRatio = refWord_q[RCNT_LSB +: RCNT_W];

  // ---------------------------------------------------------------
  // reference divider and comparator tick
  // ---------------------------------------------------------------
  logic sRefPrev_q, sRefPrev_d;
  logic [RCNT_W-1:0] rCnt_q, rCnt_d;
  logic tick_q, tick_d;
  logic refEdge;

  // falling edge only, or both edges with the doubler on
  assign refEdge = dblr ? (sRef ^ sRefPrev_q) : (!sRef && sRefPrev_q);

  // a ratio of zero is illegal and is treated as one
  always_comb begin
    sRefPrev_d = sRef;
    rCnt_d = rCnt_q;
    tick_d = 1'b0;
    if (cntRst) begin
      rCnt_d = 4'h0;
    end else if (refEdge) begin
      if (rCnt_q + 4'h1 >= rRatio) begin
        rCnt_d = 4'h0;
        tick_d = 1'b1;
      end else begin
        rCnt_d = rCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sRefPrev_q <= 1'b0;
      rCnt_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      sRefPrev_q <= sRefPrev_d;
      rCnt_q <= rCnt_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // digital lock detect
  // ---------------------------------------------------------------
  logic [ERR_W-1:0] errLen_q, errLen_d, errMax_q, errMax_d;
  logic [CNT_W-1:0] good_q, good_d;
  logic lock_q, lock_d;
  logic [CNT_W-1:0] target;

  assign target = lockLong ? LOCK_COUNT_LONG : LOCK_COUNT_SHORT;

  // error pulse width is measured in clk cycles and judged each tick;
  // at 50 ns resolution a good cycle means no error pulse at all
  always_comb begin
    errLen_d = sErr ? errLen_q + 4'h1 : 4'h0;
    if (sErr && errLen_q == 4'hF) begin
      errLen_d = errLen_q;
    end
    errMax_d = (errLen_d > errMax_q) ? errLen_d : errMax_q;
    good_d = good_q;
    lock_d = lock_q;
    if (tick_q) begin
      errMax_d = errLen_d;
      if (errMax_q < 4'(LOCK_CYC)) begin
        if (good_q != target) begin
          good_d = good_q + 6'h01;
        end
        if (good_q + 6'h01 >= target) begin
          lock_d = 1'b1;
        end
      end else begin
        good_d = 6'h00;
      end
      if (errMax_q >= 4'(UNLOCK_CYC)) begin
        lock_d = 1'b0;
      end
    end
    if (newChannel || pd) begin
      good_d = 6'h00;
      lock_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      errLen_q <= 4'h0;
      errMax_q <= 4'h0;
      good_q <= 6'h00;
      lock_q <= 1'b0;
    end else begin
      errLen_q <= errLen_d;
      errMax_q <= errMax_d;
      good_q <= good_d;
      lock_q <= lock_d;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  logic [CPCUR_W-1:0] cpCur_d;
  logic muxO_d, muxOe_d;

  always_comb begin
    cpCur_d = fastLock ? CPCUR_MAX : ctrlWord_q[CPCUR_LSB +: CPCUR_W];
    muxO_d = 1'b0;
    muxOe_d = 1'b0;
    unique case (refWord_q[MUXSEL_LSB +: MUXSEL_W])
      MUX_FASTLOCK_SW: begin
        muxO_d = 1'b0;
        muxOe_d = fastLock;
      end
      MUX_LOCK_DETECT: begin
        muxO_d = lock_q;
        muxOe_d = 1'b1;
      end
      default: begin
        muxO_d = 1'b0;
        muxOe_d = 1'b0;
      end
    endcase
  end

  // outputs registered once more so every port leaves a flip-flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wholeDivide <= 9'h000;
      fractionNumerator <= 12'h000;
      fractionModulus <= MOD_RESET;
      resyncDelay <= 12'h000;
      referenceRatio <= 4'h0;
      prescalerHigh <= 1'b0;
      chargePumpCurrent <= 4'h0;
      chargePumpTristate <= 1'b1;
      chargePumpLowNoise <= 1'b0;
      phasePolarity <= 1'b0;
      countersReset <= 1'b1;
      powerDown <= 1'b0;
      ditherEnable <= 1'b0;
      resyncCount <= 4'h0;
      comparatorTick <= 1'b0;
      lockDetect <= 1'b0;
      muxOutOut <= 1'b0;
      muxOutOe <= 1'b0;
    end else begin
      wholeDivide <= fbWord_q[INT_LSB +: INT_W];
      fractionNumerator <= fbWord_q[FRACTION_NUMERATOR_LSB +: FRACTION_NUMERATOR_W];
      fractionModulus <= modAct_q;
      resyncDelay <= resync_q;
      referenceRatio <= rRatio;
      prescalerHigh <= refWord_q[PRESC_BIT];
      chargePumpCurrent <= cpCur_d;
      chargePumpTristate <= ctrlWord_q[CPTRI_BIT] | pd;
      chargePumpLowNoise <= (nsMode == NS_LOWEST_NOISE);
      phasePolarity <= ctrlWord_q[POLAR_BIT];
      countersReset <= cntRst;
      powerDown <= pd;
      ditherEnable <= (nsMode == NS_LOW_SPUR);
      resyncCount <= ctrlWord_q[RESYNC_LSB +: RESYNC_W];
      comparatorTick <= tick_q;
      lockDetect <= lock_q;
      muxOutOut <= muxO_d;
      muxOutOe <= muxOe_d;
    end
  end
endmodule : fsprg_regs

// File: verilog/fsprg_sync.sv
/*
 * fsprg_sync: three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk; output changes only when
 * the second and third stages agree.
 */
`timescale 1ns/10ps
module fsprg_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pinIn,
  output logic syncOut
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic out_q;
  logic out_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // only stages two and three are compared; stage one feeds stage two
  always_comb begin
    stage_d = {stage_q[1:0], pinIn};
    out_d = out_q;
    if (stage_q[1] == stage_q[2]) begin
      out_d = stage_q[2];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule : fsprg_sync
